/* File: hw/afsi_pkg.sv */
// Function
// - Hold all logic, registers included, in reset while supply is invalid.
// - Leave hardware shutdown only with valid supply and pin released.
// - Supply dropping below reset threshold forces reset at once.
// - Battery under- or overvoltage powers analog core down immediately.
// - Lockout faults hold until a shutdown cycle; live and latched show them.
// - Serial clock faults force software shutdown as quickly as possible.
// - When clock errors clear, ramp back to the prior playback state.
// - Clock error drives the interrupt pin when mask bit 2 is zero.
// - Reading a latched status register clears it.
// - Thermal or current faults force software shutdown and raise interrupt.
// - Per-fault retry select chooses latching or automatic retry.
// - No switching resumes until 1.5 s after a thermal or current fault.
// - Limiter conditions are reported in status and may raise the interrupt.
// - Interrupt pin is open drain, low while an unmasked fault exists.
// - Internal interrupt pull-up follows its enable bit, default off.
// - Pin source select 00 live, 01 latched (default), others reserved.
// - Input pull-downs per enable bit, default on, off in hardware shutdown.
// - Software shutdown is mode 10; fault shutdown uses the same ramp.
package afsi_pkg;
  localparam logic [7:0] ADDR_MASK_A    = 8'h20;
  localparam logic [7:0] ADDR_MASK_B    = 8'h21;
  localparam logic [7:0] ADDR_LIVE_A    = 8'h22;
  localparam logic [7:0] ADDR_LIVE_B    = 8'h23;
  localparam logic [7:0] ADDR_LTCH_A    = 8'h24;
  localparam logic [7:0] ADDR_LTCH_B    = 8'h25;
  localparam logic [7:0] ADDR_PIN_CFG   = 8'h30;
  localparam logic [7:0] ADDR_PULLDOWN  = 8'h31;
  localparam logic [7:0] ADDR_MISC_IRQ  = 8'h32;

  localparam logic [7:0] RST_MASK_A     = 8'hfc;
  localparam logic [7:0] RST_MASK_B     = 8'h0f;
  localparam logic [7:0] RST_PIN_CFG    = 8'h01;
  localparam logic [7:0] RST_PULLDOWN   = 8'he5;
  localparam logic [7:0] RST_MISC_IRQ   = 8'h00;
  localparam logic [7:0] PULLDOWN_USED  = 8'he5;
  localparam logic [7:0] MASK_B_USED    = 8'h0f;

  localparam int         NUM_SRC        = 12;
  localparam int         SRC_OVERTEMP   = 0;
  localparam int         SRC_OVERCUR    = 1;
  localparam int         SRC_CLKERR     = 2;
  localparam int         SRC_UNDERVOLTAGE_LOCKOUT       = 10;
  localparam int         SRC_OVERVOLTAGE_LOCKOUT       = 11;

  localparam int         CFG_SEL_LSB    = 0;
  localparam int         CFG_PULLUP_BIT = 2;
  localparam int         MISC_OT_RETRY  = 0;
  localparam int         MISC_OC_RETRY  = 1;

  localparam logic [1:0] PIN_SRC_LIVE   = 2'h0;
  localparam logic [1:0] PIN_SRC_LTCH   = 2'h1;
  localparam logic [1:0] MODE_ACTIVE    = 2'h0;
  localparam logic [1:0] MODE_SW_SHDN   = 2'h2;

  localparam int         CLK_HZ         = 10_000_000;
  localparam int         RETRY_MS       = 1500;
  localparam int         RETRY_CYCLES   = CLK_HZ / 1000 * RETRY_MS;
  localparam int         RETRY_W        = 24;

  typedef enum logic [1:0]
  {
    AFSI_RUN   = 2'b00,
    AFSI_WAIT  = 2'b01,
    AFSI_HOLD  = 2'b11
  } afsi_retry_t;
endpackage

/* File: hw/afsi_retry.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------------
// Retry timer for one thermal or current fault
// ----------------------------------------------------------------------
module afsi_retry #(
  parameter int RETRY_CYCLES = afsi_pkg::RETRY_CYCLES
) (
  input  wire logic I_REF_CLK,
  input  wire logic I_RST_N,
  input  wire logic i_fault,
  input  wire logic i_retry_sel,
  input  wire logic i_shdn_cycle,
  output logic      o_block
);
  afsi_pkg::afsi_retry_t          state_reg;
  afsi_pkg::afsi_retry_t          state_next;
  logic [afsi_pkg::RETRY_W-1:0]   count_reg;
  logic [afsi_pkg::RETRY_W-1:0]   count_next;
  logic                           done;
  logic                           rearm_reg;
  logic                           rearm_next;

  // The timer runs off the reference clock, never the audio clocks.
  assign done = (count_reg == afsi_pkg::RETRY_W'(RETRY_CYCLES - 1));

  always_comb
  begin
    state_next = state_reg;
    count_next = count_reg;
    // A shutdown cycle seen during the delay releases a latching fault
    // once the delay ends, so no second cycle is needed.
    rearm_next = rearm_reg | i_shdn_cycle;
    case (state_reg)
      afsi_pkg::AFSI_RUN:
      begin
        rearm_next = 1'b0;
        if (i_fault)
        begin
          state_next = afsi_pkg::AFSI_WAIT;
          count_next = '0;
        end
      end
      afsi_pkg::AFSI_WAIT:
      begin
        // A fault still present restarts the full delay.
        if (i_fault)
          count_next = '0;
        else if (!done)
          count_next = count_reg + 1'b1;
        else if (i_retry_sel || rearm_next)
          state_next = afsi_pkg::AFSI_RUN;
        else
          state_next = afsi_pkg::AFSI_HOLD;
      end
      afsi_pkg::AFSI_HOLD:
      begin
        // A shutdown cycle re-arms, but the delay has already elapsed.
        if (i_shdn_cycle)
          state_next = afsi_pkg::AFSI_RUN;
        if (i_fault)
        begin
          state_next = afsi_pkg::AFSI_WAIT;
          count_next = '0;
          rearm_next = 1'b0;
        end
      end
      default:
        state_next = afsi_pkg::AFSI_RUN;
    endcase
  end

  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      state_reg <= afsi_pkg::AFSI_RUN;
      count_reg <= '0;
      rearm_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      count_reg <= count_next;
      rearm_reg <= rearm_next;
    end
  end

  assign o_block = (state_reg != afsi_pkg::AFSI_RUN) || i_fault;
endmodule
`default_nettype wire

/* File: hw/afsi_top.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------------
// Fault supervision, status and interrupt pin
// ----------------------------------------------------------------------
module afsi_top #(
  parameter int RETRY_CYCLES = afsi_pkg::RETRY_CYCLES
) (
  input  wire logic       I_REF_CLK,
  input  wire logic       I_RST_N,
  input  wire logic       I_ANALOG_SUPPLY_OK,
  input  wire logic       I_SHUTDOWN_N_PIN,
  input  wire logic       I_UNDERVOLTAGE_LOCKOUT,
  input  wire logic       I_OVERVOLTAGE_LOCKOUT,
  input  wire logic       I_CLK_RATIO_ERR,
  input  wire logic       I_FRAME_SYNC_FREQ_ERR,
  input  wire logic       I_CLK_HALT_ERR,
  input  wire logic       I_OVERTEMP,
  input  wire logic       I_OVERCURRENT,
  input  wire logic [4:0] I_LIMITER_FLAGS,
  input  wire logic       I_PDM_CLK_ERR,
  input  wire logic       I_BROWN_OUT,
  input  wire logic [1:0] I_MODE,
  input  wire logic       I_REG_WR,
  input  wire logic       I_REG_RD,
  input  wire logic [7:0] I_REG_ADDR,
  input  wire logic [7:0] I_REG_WDATA,
  output logic      [7:0] O_REG_RDATA,
  output logic            O_CORE_RESET,
  output logic            O_DIG_REG_EN,
  output logic            O_ANALOG_PD,
  output logic      [1:0] O_EFF_MODE,
  output logic            O_RAMP_DOWN,
  output logic            O_FAULT_IRQ_N_PIN_OUT,
  output logic            O_FAULT_IRQ_N_PIN_OE,
  output logic            O_IRQ_PULLUP_EN,
  output logic      [7:0] O_INPUT_PULLDOWN_EN
);
  localparam int N = afsi_pkg::NUM_SRC;

  // --------------------------------------------------------------------
  // Power state
  // --------------------------------------------------------------------
  logic             srst_n;
  logic             hw_shdn;
  logic             sw_shdn;
  logic             shdn_cycle;
  logic             sw_shdn_reg;
  logic             sw_shdn_q_reg;

  // Supply loss resets everything, registers included.
  assign srst_n  = I_RST_N & I_ANALOG_SUPPLY_OK;
  // Hardware shutdown ends only with supply valid and pin released.
  assign hw_shdn = ~I_SHUTDOWN_N_PIN;
  // Mode 10 is the software shutdown state.
  assign sw_shdn = (I_MODE == afsi_pkg::MODE_SW_SHDN);
  assign shdn_cycle = hw_shdn | (sw_shdn_reg & ~sw_shdn_q_reg);

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  logic [7:0]   mask_a_reg, mask_a_next;
  logic [7:0]   mask_b_reg, mask_b_next;
  logic [7:0]   pin_cfg_reg, pin_cfg_next;
  logic [7:0]   pd_reg, pd_next;
  logic [7:0]   misc_reg, misc_next;
  logic [N-1:0] live_reg, live_next;
  logic [N-1:0] ltch_reg, ltch_next;
  logic [N-1:0] cond;
  logic [N-1:0] rd_clr;
  logic [N-1:0] mask;
  logic [7:0]   rdata_next;
  logic         clk_err;
  logic         ot_block;
  logic         oc_block;
  logic         lock_reg, lock_next;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  assign clk_err = I_CLK_RATIO_ERR | I_FRAME_SYNC_FREQ_ERR | I_CLK_HALT_ERR;
  assign cond = {I_OVERVOLTAGE_LOCKOUT, I_UNDERVOLTAGE_LOCKOUT, I_BROWN_OUT,
                 I_PDM_CLK_ERR, I_LIMITER_FLAGS, clk_err, I_OVERCURRENT,
                 I_OVERTEMP};
  assign mask = {mask_b_reg[3:0], mask_a_reg};

  // Reading a latched register clears only its own byte.
  always_comb
  begin
    rd_clr = '0;
    if (I_REG_RD && hit(I_REG_ADDR, afsi_pkg::ADDR_LTCH_A))
      rd_clr[7:0] = 8'hff;
    if (I_REG_RD && hit(I_REG_ADDR, afsi_pkg::ADDR_LTCH_B))
      rd_clr[N-1:8] = 4'hf;
  end

  always_comb
  begin
    mask_a_next = mask_a_reg;
    mask_b_next = mask_b_reg;
    pin_cfg_next = pin_cfg_reg;
    pd_next = pd_reg;
    misc_next = misc_reg;
    if (I_REG_WR)
    begin
      if (hit(I_REG_ADDR, afsi_pkg::ADDR_MASK_A))
        mask_a_next = I_REG_WDATA;
      if (hit(I_REG_ADDR, afsi_pkg::ADDR_MASK_B))
        mask_b_next = I_REG_WDATA & afsi_pkg::MASK_B_USED;
      if (hit(I_REG_ADDR, afsi_pkg::ADDR_PIN_CFG))
        pin_cfg_next = I_REG_WDATA;
      if (hit(I_REG_ADDR, afsi_pkg::ADDR_PULLDOWN))
        pd_next = I_REG_WDATA & afsi_pkg::PULLDOWN_USED;
      if (hit(I_REG_ADDR, afsi_pkg::ADDR_MISC_IRQ))
        misc_next = I_REG_WDATA;
    end
    // Live bits track conditions every cycle.
    live_next = cond;
    // A set arriving with a read-clear wins, so no event is lost.
    ltch_next = (ltch_reg & ~rd_clr) | cond;
    // Lockout stays until a shutdown cycle, independent of status reads.
    // A lockout present during a shutdown cycle still sets it, as set wins.
    lock_next = (lock_reg & ~shdn_cycle) | I_UNDERVOLTAGE_LOCKOUT
              | I_OVERVOLTAGE_LOCKOUT;
    rdata_next = 8'h00;
    if (I_REG_RD)
    begin
      case (I_REG_ADDR)
        afsi_pkg::ADDR_MASK_A:   rdata_next = mask_a_reg;
        afsi_pkg::ADDR_MASK_B:   rdata_next = mask_b_reg;
        afsi_pkg::ADDR_LIVE_A:   rdata_next = live_reg[7:0];
        afsi_pkg::ADDR_LIVE_B:   rdata_next = {4'h0, live_reg[N-1:8]};
        afsi_pkg::ADDR_LTCH_A:   rdata_next = ltch_reg[7:0];
        afsi_pkg::ADDR_LTCH_B:   rdata_next = {4'h0, ltch_reg[N-1:8]};
        afsi_pkg::ADDR_PIN_CFG:  rdata_next = pin_cfg_reg;
        afsi_pkg::ADDR_PULLDOWN: rdata_next = pd_reg;
        afsi_pkg::ADDR_MISC_IRQ: rdata_next = misc_reg;
        default:                 rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge I_REF_CLK or negedge srst_n)
  begin
    if (!srst_n)
    begin
      mask_a_reg    <= afsi_pkg::RST_MASK_A;
      mask_b_reg    <= afsi_pkg::RST_MASK_B;
      pin_cfg_reg   <= afsi_pkg::RST_PIN_CFG;
      pd_reg        <= afsi_pkg::RST_PULLDOWN;
      misc_reg      <= afsi_pkg::RST_MISC_IRQ;
      live_reg      <= '0;
      ltch_reg      <= '0;
      lock_reg      <= 1'b0;
      O_REG_RDATA   <= 8'h00;
      sw_shdn_reg   <= 1'b0;
      sw_shdn_q_reg <= 1'b0;
    end
    else
    begin
      mask_a_reg    <= mask_a_next;
      mask_b_reg    <= mask_b_next;
      pin_cfg_reg   <= pin_cfg_next;
      pd_reg        <= pd_next;
      misc_reg      <= misc_next;
      live_reg      <= live_next;
      ltch_reg      <= ltch_next;
      lock_reg      <= lock_next;
      O_REG_RDATA   <= rdata_next;
      sw_shdn_reg   <= sw_shdn;
      sw_shdn_q_reg <= sw_shdn_reg;
    end
  end

  // --------------------------------------------------------------------
  // Retry timers
  // --------------------------------------------------------------------
  afsi_retry #(
    .RETRY_CYCLES (RETRY_CYCLES)
  ) u_ot_retry (
    .I_REF_CLK    (I_REF_CLK),
    .I_RST_N      (srst_n),
    .i_fault      (I_OVERTEMP),
    .i_retry_sel  (misc_reg[afsi_pkg::MISC_OT_RETRY]),
    .i_shdn_cycle (shdn_cycle),
    .o_block      (ot_block)
  );

  afsi_retry #(
    .RETRY_CYCLES (RETRY_CYCLES)
  ) u_oc_retry (
    .I_REF_CLK    (I_REF_CLK),
    .I_RST_N      (srst_n),
    .i_fault      (I_OVERCURRENT),
    .i_retry_sel  (misc_reg[afsi_pkg::MISC_OC_RETRY]),
    .i_shdn_cycle (shdn_cycle),
    .o_block      (oc_block)
  );

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  logic [1:0] eff_mode_next;
  logic       force_shdn;
  logic       irq_next;
  logic       analog_pd_next;
  logic [1:0] sel;

  assign sel = pin_cfg_reg[afsi_pkg::CFG_SEL_LSB +: 2];

  always_comb
  begin
    // Clock, thermal and current faults force shutdown; clearing the
    // clock error hands back the host's mode, so playback resumes.
    force_shdn = clk_err | ot_block | oc_block;
    eff_mode_next = force_shdn ? afsi_pkg::MODE_SW_SHDN : I_MODE;
    // Lockout powers the analog core down without waiting a cycle.
    analog_pd_next = hw_shdn | lock_next;
    // Reserved select codes leave the pin released.
    case (sel)
      afsi_pkg::PIN_SRC_LIVE: irq_next = |(live_next & ~mask);
      afsi_pkg::PIN_SRC_LTCH: irq_next = |(ltch_next & ~mask);
      default:                irq_next = 1'b0;
    endcase
  end

  always_ff @(posedge I_REF_CLK or negedge srst_n)
  begin
    if (!srst_n)
    begin
      O_CORE_RESET          <= 1'b1;
      O_DIG_REG_EN          <= 1'b0;
      O_ANALOG_PD           <= 1'b1;
      O_EFF_MODE            <= afsi_pkg::MODE_SW_SHDN;
      O_RAMP_DOWN           <= 1'b0;
      O_FAULT_IRQ_N_PIN_OUT <= 1'b0;
      O_FAULT_IRQ_N_PIN_OE  <= 1'b0;
      O_IRQ_PULLUP_EN       <= 1'b0;
      O_INPUT_PULLDOWN_EN   <= 8'h00;
    end
    else
    begin
      O_CORE_RESET          <= hw_shdn;
      O_DIG_REG_EN          <= ~hw_shdn;
      O_ANALOG_PD           <= analog_pd_next;
      O_EFF_MODE            <= eff_mode_next;
      // Fault shutdown goes through the normal volume ramp.
      O_RAMP_DOWN           <= force_shdn & (I_MODE != afsi_pkg::MODE_SW_SHDN);
      // Open drain: drive low only, never high.
      O_FAULT_IRQ_N_PIN_OUT <= 1'b0;
      O_FAULT_IRQ_N_PIN_OE  <= irq_next;
      O_IRQ_PULLUP_EN       <= pin_cfg_reg[afsi_pkg::CFG_PULLUP_BIT];
      O_INPUT_PULLDOWN_EN   <= hw_shdn ? 8'h00 : pd_reg;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/afsi_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
// ----
// Port checker for the fault and interrupt block
// ----
module afsi_chk (
  input wire logic       I_REF_CLK,
  input wire logic       I_RST_N,
  input wire logic       I_ANALOG_SUPPLY_OK,
  input wire logic       I_SHUTDOWN_N_PIN,
  input wire logic       I_UNDERVOLTAGE_LOCKOUT,
  input wire logic       I_OVERVOLTAGE_LOCKOUT,
  input wire logic       I_CLK_RATIO_ERR,
  input wire logic       I_FRAME_SYNC_FREQ_ERR,
  input wire logic       I_CLK_HALT_ERR,
  input wire logic       I_OVERTEMP,
  input wire logic       I_OVERCURRENT,
  input wire logic [4:0] I_LIMITER_FLAGS,
  input wire logic       I_PDM_CLK_ERR,
  input wire logic       I_BROWN_OUT,
  input wire logic [1:0] I_MODE,
  input wire logic       I_REG_WR,
  input wire logic [7:0] O_REG_RDATA,
  input wire logic       O_CORE_RESET,
  input wire logic       O_DIG_REG_EN,
  input wire logic       O_ANALOG_PD,
  input wire logic [1:0] O_EFF_MODE,
  input wire logic       O_RAMP_DOWN,
  input wire logic       O_FAULT_IRQ_N_PIN_OUT,
  input wire logic       O_FAULT_IRQ_N_PIN_OE,
  input wire logic       O_IRQ_PULLUP_EN,
  input wire logic [7:0] O_INPUT_PULLDOWN_EN
);
  wire logic src_any;
  assign src_any = |{I_UNDERVOLTAGE_LOCKOUT, I_OVERVOLTAGE_LOCKOUT,
    I_CLK_RATIO_ERR, I_FRAME_SYNC_FREQ_ERR, I_CLK_HALT_ERR, I_OVERTEMP,
    I_OVERCURRENT, I_LIMITER_FLAGS, I_PDM_CLK_ERR, I_BROWN_OUT};
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (!I_RST_N);
  sequence s_clk_err;
    (I_CLK_RATIO_ERR || I_FRAME_SYNC_FREQ_ERR || I_CLK_HALT_ERR)
      && I_SHUTDOWN_N_PIN && I_ANALOG_SUPPLY_OK;
  endsequence
  chk_supply_reset: assert property (
    !I_ANALOG_SUPPLY_OK |-> O_CORE_RESET && !O_IRQ_PULLUP_EN
      && !O_FAULT_IRQ_N_PIN_OE && O_REG_RDATA == 8'h00)
    else $error("outputs not held in reset while supply invalid");
  chk_hw_shdn: assert property (
    !I_SHUTDOWN_N_PIN |=> O_CORE_RESET && !O_DIG_REG_EN
      && O_INPUT_PULLDOWN_EN == 8'h00)
    else $error("hardware shutdown not applied");
  chk_core_up: assert property (
    (I_SHUTDOWN_N_PIN && I_ANALOG_SUPPLY_OK) ##1 I_ANALOG_SUPPLY_OK
      |-> O_DIG_REG_EN && !O_CORE_RESET)
    else $error("core not released after shutdown pin");
  chk_lockout_pd: assert property (
    (I_UNDERVOLTAGE_LOCKOUT || I_OVERVOLTAGE_LOCKOUT) |=> O_ANALOG_PD)
    else $error("analog core not powered down on lockout");
  chk_clk_err_shdn: assert property (
    s_clk_err |=> O_EFF_MODE == afsi_pkg::MODE_SW_SHDN)
    else $error("clock error did not force shutdown");
  chk_ramp_on_err: assert property (
    s_clk_err ##0 (I_MODE != afsi_pkg::MODE_SW_SHDN) ##1 I_ANALOG_SUPPLY_OK
      |-> O_RAMP_DOWN)
    else $error("forced shutdown without ramp down");
  chk_thermal_shdn: assert property (
    (I_OVERTEMP || I_OVERCURRENT) && I_SHUTDOWN_N_PIN
      |-> ##[1:2] O_EFF_MODE == afsi_pkg::MODE_SW_SHDN)
    else $error("thermal or current fault did not force shutdown");
  chk_mode_follow: assert property (
    O_EFF_MODE != afsi_pkg::MODE_SW_SHDN |-> O_EFF_MODE == $past(I_MODE))
    else $error("running mode differs from host mode");
  chk_irq_cause: assert property (
    $rose(O_FAULT_IRQ_N_PIN_OE) && !$past(I_REG_WR) && !$past(I_REG_WR, 2)
      |-> $past(src_any) && !O_FAULT_IRQ_N_PIN_OUT)
    else $error("interrupt pin pulled low without a source");
endmodule
bind afsi_top afsi_chk i_chk (.I_REF_CLK, .I_RST_N, .I_ANALOG_SUPPLY_OK,
  .I_SHUTDOWN_N_PIN, .I_UNDERVOLTAGE_LOCKOUT, .I_OVERVOLTAGE_LOCKOUT,
  .I_CLK_RATIO_ERR, .I_FRAME_SYNC_FREQ_ERR, .I_CLK_HALT_ERR, .I_OVERTEMP,
  .I_OVERCURRENT, .I_LIMITER_FLAGS, .I_PDM_CLK_ERR, .I_BROWN_OUT, .I_MODE,
  .I_REG_WR, .O_REG_RDATA, .O_CORE_RESET, .O_DIG_REG_EN, .O_ANALOG_PD,
  .O_EFF_MODE, .O_RAMP_DOWN, .O_FAULT_IRQ_N_PIN_OUT, .O_FAULT_IRQ_N_PIN_OE,
  .O_IRQ_PULLUP_EN, .O_INPUT_PULLDOWN_EN);
`default_nettype wire

/* File: testbench/afsi_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ----
// Host side of the interrupt line
// ----
module afsi_host_model (
  input  wire logic i_out,
  input  wire logic i_oe,
  output logic      o_irq_n
);
  // The board resistor pulls the line high whenever nobody sinks it.
  assign o_irq_n = (i_oe && !i_out) ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) \
  begin \
    comparisons++; \
    if ((a) !== (b)) \
    begin \
      $display("[ERR] %0t got %h exp %h", $time, a, b); \
      failures++; \
    end \
  end
module tb_top;
  logic clk = 1'b0, rst_n = 1'b0, sup = 1'b1, sd_n = 1'b1, uv = 1'b0;
  logic ov = 1'b0, rat = 1'b0, fs = 1'b0, hlt = 1'b0, ot = 1'b0, oc = 1'b0;
  logic pdm = 1'b0, bo = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [4:0] lim = 5'h00;
  logic [1:0] mode = 2'h0;
  logic [7:0] addr = 8'h00, wd = 8'h00;
  wire logic [7:0] rdata, pd;
  wire logic [1:0] emode;
  wire logic core_rst, dig_en, apd, ramp, irq_out, irq_oe, pu, irq_n;
  int failures = 0, comparisons = 0, cycles = 0;
  localparam logic [7:0] A_TAB [9] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24,
    8'h25, 8'h30, 8'h31, 8'h32};
  localparam logic [7:0] D_TAB [9] = '{8'hfc, 8'h0f, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h01, 8'he5, 8'h00};
  afsi_top #(.RETRY_CYCLES(20)) i_dut (.I_REF_CLK(clk), .I_RST_N(rst_n),
    .I_ANALOG_SUPPLY_OK(sup), .I_SHUTDOWN_N_PIN(sd_n),
    .I_UNDERVOLTAGE_LOCKOUT(uv), .I_OVERVOLTAGE_LOCKOUT(ov),
    .I_CLK_RATIO_ERR(rat), .I_FRAME_SYNC_FREQ_ERR(fs), .I_CLK_HALT_ERR(hlt),
    .I_OVERTEMP(ot), .I_OVERCURRENT(oc), .I_LIMITER_FLAGS(lim),
    .I_PDM_CLK_ERR(pdm), .I_BROWN_OUT(bo), .I_MODE(mode), .I_REG_WR(wr),
    .I_REG_RD(rd), .I_REG_ADDR(addr), .I_REG_WDATA(wd), .O_REG_RDATA(rdata),
    .O_CORE_RESET(core_rst), .O_DIG_REG_EN(dig_en), .O_ANALOG_PD(apd),
    .O_EFF_MODE(emode), .O_RAMP_DOWN(ramp), .O_FAULT_IRQ_N_PIN_OUT(irq_out),
    .O_FAULT_IRQ_N_PIN_OE(irq_oe), .O_IRQ_PULLUP_EN(pu),
    .O_INPUT_PULLDOWN_EN(pd));
  afsi_host_model i_host (.i_out(irq_out), .i_oe(irq_oe), .o_irq_n(irq_n));
  initial forever #50 clk = ~clk;
  task automatic test_done();
    if (failures == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      test_done();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stands for one cycle only, so it is sampled mid-cycle.
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    `CHK(rdata, e)
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    cyc(1);
    for (int i = 0; i < 9; i++) rc(A_TAB[i], D_TAB[i]);
    `CHK(pd, 8'he5)
    `CHK(pu, 1'b0)
    `CHK(irq_n, 1'b1)
    wreg(8'h26, 8'hff);
    rc(8'h26, 8'h00);
    wreg(8'h31, 8'hff);
    rc(8'h31, 8'he5);
    wreg(8'h21, 8'hff);
    rc(8'h21, 8'h0f);
    wreg(8'h22, 8'hff);
    rc(8'h22, 8'h00);
    wreg(8'h30, 8'h05);
    cyc(1);
    `CHK(pu, 1'b1)
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk) {hlt, fs, rat} <= 3'h1 << i;
      mode <= (i == 1) ? 2'h1 : 2'h0;
      cyc(2);
      `CHK(emode, 2'h2)
      `CHK(ramp, 1'b1)
      `CHK(irq_n, 1'b1)
      rc(8'h22, 8'h04);
      @(posedge clk) {hlt, fs, rat} <= 3'h0;
      cyc(2);
      `CHK(emode, mode)
      `CHK(ramp, 1'b0)
      rc(8'h24, 8'h04);
      rc(8'h24, 8'h00);
    end
    // Unmasked clock error, first through the latched source, then live.
    for (int j = 0; j < 2; j++)
    begin
      wreg(8'h20, 8'hf8);
      wreg(8'h30, j ? 8'h04 : 8'h05);
      @(posedge clk) rat <= 1'b1;
      cyc(2);
      `CHK(irq_n, 1'b0)
      @(posedge clk) rat <= 1'b0;
      cyc(2);
      `CHK(irq_n, j ? 1'b1 : 1'b0)
      rc(8'h24, 8'h04);
      cyc(1);
      `CHK(irq_n, 1'b1)
    end
    wreg(8'h20, 8'h00);
    wreg(8'h21, 8'h00);
    for (int i = 0; i < 7; i++)
    begin
      @(posedge clk) {bo, pdm, lim} <= 7'h01 << i;
      cyc(2);
      `CHK(irq_n, 1'b0)
      if (i < 5) rc(8'h22, 8'h08 << i);
      else rc(8'h23, 8'h01 << (i - 5));
      @(posedge clk) {bo, pdm, lim} <= 7'h00;
    end
    rc(8'h24, 8'hf8);
    rc(8'h25, 8'h03);
    wreg(8'h30, 8'h05);
    wreg(8'h32, 8'h01);
    @(posedge clk) ot <= 1'b1;
    cyc(2);
    `CHK(emode, 2'h2)
    `CHK(irq_n, 1'b0)
    @(posedge clk) ot <= 1'b0;
    cyc(8);
    `CHK(emode, 2'h2)
    cyc(20);
    `CHK(emode, 2'h0)
    rc(8'h24, 8'h01);
    @(posedge clk) oc <= 1'b1;
    cyc(2);
    @(posedge clk) oc <= 1'b0;
    cyc(30);
    `CHK(emode, 2'h2)
    rc(8'h24, 8'h02);
    for (int j = 0; j < 2; j++)
    begin
      // Both ends of the lockout latch: mode 10 entry, then the pin.
      @(posedge clk) mode <= 2'h2;
      cyc(2);
      @(posedge clk) mode <= 2'h0;
      cyc(2);
      `CHK(emode, 2'h0)
      @(posedge clk) {ov, uv} <= 2'h1 << j;
      cyc(2);
      `CHK(apd, 1'b1)
      rc(8'h23, 8'h04 << j);
      @(posedge clk) {ov, uv} <= 2'h0;
      cyc(2);
      `CHK(apd, 1'b1)
      rc(8'h25, 8'h04 << j);
      @(posedge clk) if (j) sd_n <= 1'b0; else mode <= 2'h2;
      cyc(2);
      `CHK(pd, j ? 8'h00 : 8'he5)
      @(posedge clk) sd_n <= 1'b1;
      mode <= 2'h0;
      cyc(2);
      `CHK(apd, 1'b0)
    end
    // A shutdown cycle inside the delay releases a latching fault later.
    @(posedge clk) oc <= 1'b1;
    @(posedge clk) oc <= 1'b0;
    mode <= 2'h2;
    @(posedge clk) mode <= 2'h0;
    cyc(8);
    `CHK(emode, 2'h2)
    cyc(15);
    `CHK(emode, 2'h0)
    wreg(8'h30, 8'h00);
    @(posedge clk) sup <= 1'b0;
    cyc(3);
    `CHK(core_rst, 1'b1)
    @(posedge clk) sup <= 1'b1;
    cyc(1);
    `CHK(dig_en, 1'b1)
    rc(8'h30, 8'h01);
    test_done();
  end
endmodule
`default_nettype wire
